// [rtl/dacsio_regs.sv]
// Purpose: simultaneous-update, event timer and digital I/O byte registers
// Assumes: host byte accesses synchronous to clk_i; load input synchronous-ish, resynchronised anyway
// Notes: control and interrupt registers live elsewhere and join by ports
`default_nettype none
// Overview of operation
// - bits 7..5 of update register read zero
// - reset clears all update register bits
// - load rising edge sets sticky seen flag
// - writing one to bit 4 clears flag
// - load request only when load enable set
// - held pairs store data without converting
// - clearing hold converts last stored values
// - load edge clears every hold bit
// - timer expiry sets event, optional request
// - timer output drives connector pin
// - divisor read returns last written value
// - source is 100 kHz or 1 kHz
// - divisor resets to zero
// - output lines drive low for a written zero, release for a one
// - I/O read returns sampled pin levels
// - control bit 1 picks fast source
// - control bit 0 runs timer, stop clears event
// - enabled load event raises request unless already pending
// - load pending stays until disabled or cleared
module dacsio_regs #(
	parameter int DIO_WIDTH = 8,
	parameter int FAST_CYCLES = dacsio_pkg::FAST_TICK_CYCLES,
	parameter int SLOW_CYCLES = dacsio_pkg::SLOW_TICK_CYCLES
) (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire dacsio_pkg::dacsio_bus_t bus_i,
	output logic [7:0] rdata_o,
	output logic rvalid_o,
	input wire logic load_ext_i,
	input wire logic timer_run_i,
	input wire logic timer_fast_i,
	input wire logic timer_event_clr_i,
	input wire logic load_irq_en_i,
	input wire logic timer_irq_en_i,
	output logic load_irq_o,
	output logic timer_event_o,
	output logic timer_irq_o,
	output logic timer_pin_o,
	output logic [3:0] pair_hold_o,
	output logic [3:0] pair_release_o,
	input wire logic [DIO_WIDTH-1:0] dio_in_i,
	output logic [DIO_WIDTH-1:0] dio_out_o,
	output logic [DIO_WIDTH-1:0] dio_oe_o
);
	// ====================================================
	// decode
	// reads decode in the read-data section; writes act on the strobe edge
	logic wr_simul;
	logic wr_timer;
	logic wr_dio;
	assign wr_simul = bus_i.wr && bus_i.addr == dacsio_pkg::OFF_SIMUL;
	assign wr_timer = bus_i.wr && bus_i.addr == dacsio_pkg::OFF_TIMER;
	assign wr_dio = bus_i.wr && bus_i.addr == dacsio_pkg::OFF_DIO;

	// ====================================================
	// load input synchroniser and edge detector
	logic load_s1_r;
	logic load_s2_r;
	logic load_prev_r;
	logic load_rise;

	// the flag moves three edges after the pin rises; a high pulse
	// shorter than one clock may be missed by the synchroniser
	// first stage feeds only the second
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			load_s1_r <= 1'b0;
			load_s2_r <= 1'b0;
			load_prev_r <= 1'b0;
		end else begin
			load_s1_r <= load_ext_i;
			load_s2_r <= load_s1_r;
			load_prev_r <= load_s2_r;
		end
	end
	assign load_rise = load_s2_r && !load_prev_r;

	// ====================================================
	// simultaneous-update register
	logic [3:0] hold_r;
	logic [3:0] hold_nxt;
	logic load_seen_r;

	// a host write replaces all four hold bits at once
	// external edge wins over a host write that would set a hold bit
	always_comb begin
		hold_nxt = hold_r;
		if (wr_simul) begin
			hold_nxt = bus_i.wdata[3:0];
		end
		if (load_rise) begin
			hold_nxt = 4'h0;
		end
	end

	// hold register
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			hold_r <= dacsio_pkg::SIMUL_RESET[3:0];
		end else begin
			hold_r <= hold_nxt;
		end
	end

	// sticky flag: an edge in the clearing cycle still sets it
	// a clearing write with bit 4 at zero leaves the flag alone
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			load_seen_r <= dacsio_pkg::SIMUL_RESET[dacsio_pkg::LOAD_SEEN_BIT];
		end else if (load_rise) begin
			load_seen_r <= 1'b1;
		end else if (wr_simul && bus_i.wdata[dacsio_pkg::LOAD_SEEN_BIT]) begin
			load_seen_r <= 1'b0;
		end
	end

	// hold state out to the conversion path, a copy of hold_r
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			pair_hold_o <= 4'h0;
		end else begin
			pair_hold_o <= hold_nxt;
		end
	end

	// one-cycle release pulse per falling pair, from a host clear or a load edge;
	// the conversion path reloads both channels of the pair on it
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			pair_release_o <= 4'h0;
		end else begin
			pair_release_o <= hold_r & ~hold_nxt;
		end
	end

	// pending request: level while flag and enable are both set
	// stays up until the host clears the flag or drops the enable
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			load_irq_o <= 1'b0;
		end else begin
			load_irq_o <= load_seen_r && load_irq_en_i;
		end
	end

	// ====================================================
	// event timer
	logic [7:0] divisor_r;
	logic expire;
	logic tick;
	logic timer_event_nxt;
	logic timer_irq_nxt;

	// readback is the stored value, never the running count
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			divisor_r <= dacsio_pkg::TIMER_RESET;
		end else if (wr_timer) begin
			divisor_r <= bus_i.wdata;
		end
	end

	// a zero divisor is outside the host's range but harmless here:
	// the divider then expires on every source tick
	dacsio_timer #(
		.FAST_CYCLES(FAST_CYCLES),
		.SLOW_CYCLES(SLOW_CYCLES)
	) u_timer (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.run_i(timer_run_i),
		.fast_i(timer_fast_i),
		.divisor_i(divisor_r),
		.expire_o(expire),
		.tick_o(tick)
	);

	// next event value: a stop clears first, then an expiry beats a
	// host clear in the same cycle so that no event is lost
	always_comb begin
		timer_event_nxt = timer_event_o;
		if (!timer_run_i) begin
			timer_event_nxt = 1'b0;
		end else if (expire) begin
			timer_event_nxt = 1'b1;
		end else if (timer_event_clr_i) begin
			timer_event_nxt = 1'b0;
		end
	end

	// sticky event flag register
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			timer_event_o <= 1'b0;
		end else begin
			timer_event_o <= timer_event_nxt;
		end
	end

	// request follows the next flag value, so it rises with the flag
	// and falls with it on a clear or a stop, never a cycle late
	assign timer_irq_nxt = timer_event_nxt && timer_irq_en_i;

	// request level towards the interrupt register
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			timer_irq_o <= 1'b0;
		end else begin
			timer_irq_o <= timer_irq_nxt;
		end
	end

	// pin is one flop behind the divider's toggle; the extra cycle of
	// lag is small against one source tick
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			timer_pin_o <= 1'b0;
		end else begin
			timer_pin_o <= tick;
		end
	end

	// ====================================================
	// digital I/O: a one releases the line (open-drain style)
	// reset leaves every line released, so nothing is driven until the
	// host writes a zero; there is no separate direction register, the
	// stored level doubles as the direction
	logic [DIO_WIDTH-1:0] dio_r;

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			dio_r <= DIO_WIDTH'(dacsio_pkg::DIO_RESET);
		end else if (wr_dio) begin
			dio_r <= bus_i.wdata[DIO_WIDTH-1:0];
		end
	end

	// drive low for a zero, release for a one so outside can drive
	// the driven level is always low; the pull-up supplies the high
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			dio_out_o <= '0;
			dio_oe_o <= '0;
		end else begin
			dio_out_o <= '0;
			dio_oe_o <= ~dio_r;
		end
	end

	// ====================================================
	// read data
	logic [7:0] simul_rd;
	logic [7:0] rdata_nxt;

	// update register as the host sees it: reserved bits forced to zero
	assign simul_rd = {3'h0, load_seen_r, hold_r};

	// other offsets belong to blocks outside this one and read zero here
	always_comb begin
		rdata_nxt = 8'h00;
		if (bus_i.rd) begin
			unique case (bus_i.addr)
				dacsio_pkg::OFF_SIMUL: rdata_nxt = simul_rd;
				dacsio_pkg::OFF_TIMER: rdata_nxt = divisor_r;
				dacsio_pkg::OFF_DIO: rdata_nxt = 8'(dio_in_i);
				default: rdata_nxt = 8'h00;
			endcase
		end
	end

	// registered one cycle after the strobe; zero between reads
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			rdata_o <= 8'h00;
		end else begin
			rdata_o <= rdata_nxt;
		end
	end

	// valid pulse marks the single cycle in which the data stands
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			rvalid_o <= 1'b0;
		end else begin
			rvalid_o <= bus_i.rd;
		end
	end
endmodule
`default_nettype wire

// [rtl/dacsio_timer.sv]
// Purpose: event timer: prescaled source tick and programmable divider
// Assumes: divisor 1..255 programmed before enabling
// Notes: expiry every divisor+1 source ticks, one-cycle pulse
`default_nettype none
module dacsio_timer #(
	parameter int FAST_CYCLES = dacsio_pkg::FAST_TICK_CYCLES,
	parameter int SLOW_CYCLES = dacsio_pkg::SLOW_TICK_CYCLES
) (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic run_i,
	input wire logic fast_i,
	input wire logic [7:0] divisor_i,
	output logic expire_o,
	output logic tick_o
);
	logic [15:0] pre_r;
	logic [7:0] cnt_r;
	logic src_tick;
	logic [15:0] pre_limit;

	// ====================================================
	// prescaler to the chosen source rate
	assign pre_limit = fast_i ? 16'(FAST_CYCLES - 1) : 16'(SLOW_CYCLES - 1);
	assign src_tick = run_i && (pre_r >= pre_limit);

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			pre_r <= 16'h0000;
		end else if (!run_i || src_tick) begin
			pre_r <= 16'h0000; // restart so first period is whole
		end else begin
			pre_r <= pre_r + 16'h0001;
		end
	end

	// divider: counts 0..divisor, so period is divisor+1 ticks
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			cnt_r <= 8'h00;
			expire_o <= 1'b0;
		end else begin
			expire_o <= 1'b0;
			if (!run_i) begin
				cnt_r <= 8'h00;
			end else if (src_tick) begin
				if (cnt_r >= divisor_i) begin
					cnt_r <= 8'h00;
					expire_o <= 1'b1;
				end else begin
					cnt_r <= cnt_r + 8'h01;
				end
			end
		end
	end

	// square-ish output pin toggles on each expiry
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			tick_o <= 1'b0;
		end else if (!run_i) begin
			tick_o <= 1'b0;
		end else if (src_tick && cnt_r >= divisor_i) begin
			tick_o <= ~tick_o;
		end
	end
endmodule
`default_nettype wire

// [shared/dacsio_pkg.sv]
// Purpose: shared constants and carriers for the analog-output card's load, timer and digital I/O registers
// Assumes: byte registers at offsets from the card base, 50 MHz system clock
// Notes: offsets are the printed byte offsets within the card's eight-byte window
`default_nettype none
package dacsio_pkg;
	// ====================================================
	// register offsets
	localparam logic [2:0] OFF_SIMUL = 3'h3;
	localparam logic [2:0] OFF_TIMER = 3'h4;
	localparam logic [2:0] OFF_DIO = 3'h5;
	// ====================================================
	// field positions and reset values
	localparam int LOAD_SEEN_BIT = 4;
	localparam int PAIR_COUNT = 4;
	localparam logic [7:0] SIMUL_RESET = 8'h00;
	localparam logic [7:0] TIMER_RESET = 8'h00;
	localparam logic [7:0] DIO_RESET = 8'hff;
	// ====================================================
	// timing: clock rate and timer source rates
	localparam int CLK_HZ = 50_000_000;
	localparam int FAST_SRC_HZ = 100_000;
	localparam int SLOW_SRC_HZ = 1_000;
	localparam int FAST_TICK_CYCLES = CLK_HZ / FAST_SRC_HZ;
	localparam int SLOW_TICK_CYCLES = CLK_HZ / SLOW_SRC_HZ;

	// host byte access
	typedef struct packed {
		logic rd;
		logic wr;
		logic [2:0] addr;
		logic [7:0] wdata;
	} dacsio_bus_t;
endpackage
`default_nettype wire

// [tb/dacsio_far_end.sv]
// Purpose: connector side of the digital lines
// Assumes: open-drain lines with pull-ups
// Notes: external source can only pull lines low
`default_nettype none
module dacsio_far_end (
	input wire logic [7:0] dio_oe_i,
	input wire logic [7:0] dio_drv_i,
	input wire logic [7:0] ext_low_i,
	output logic [7:0] dio_pin_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// ==========
	// wired level: any low driver wins, else pull-up
	assign dio_pin_o = ~((dio_oe_i & ~dio_drv_i) | ext_low_i);
endmodule
`default_nettype wire

// [tb/dacsio_regs_sva.sv]
// Purpose: port checker for the card register block
// Assumes: one clock, reset_i async active high
// Notes: bound to dacsio_regs from tb_top
`default_nettype none
module dacsio_regs_sva (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire dacsio_pkg::dacsio_bus_t bus_i,
	input wire logic [7:0] rdata_o,
	input wire logic rvalid_o,
	input wire logic load_irq_en_i,
	input wire logic load_irq_o,
	input wire logic timer_run_i,
	input wire logic timer_event_o,
	input wire logic timer_irq_o,
	input wire logic timer_pin_o,
	input wire logic [3:0] pair_hold_o,
	input wire logic [3:0] pair_release_o,
	input wire logic [7:0] dio_oe_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// ==========
	// relations between host side and pins
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (reset_i);
	property p_rd; bus_i.rd |=> rvalid_o; endproperty
	a_rd: assert property (p_rd) else $error("read not answered");
	property p_rsvd; rvalid_o && $past(bus_i.addr) == dacsio_pkg::OFF_SIMUL |-> rdata_o[7:5] == 3'h0; endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
	property p_ldirq; !$past(load_irq_en_i) |-> !load_irq_o; endproperty
	a_ldirq: assert property (p_ldirq) else $error("load request while disabled");
	property p_tmirq; timer_irq_o |-> timer_event_o; endproperty
	a_tmirq: assert property (p_tmirq) else $error("timer request without event");
	property p_stopev; !timer_run_i [*2] |-> !timer_event_o; endproperty
	a_stopev: assert property (p_stopev) else $error("event kept after stop");
	property p_stoppin; !timer_run_i [*3] |-> !timer_pin_o; endproperty
	a_stoppin: assert property (p_stoppin) else $error("timer pin high when stopped");
	// release pulse must match exactly the falling hold bits
	property p_rel; pair_release_o == ($past(pair_hold_o) & ~pair_hold_o); endproperty
	a_rel: assert property (p_rel) else $error("release pulse wrong");
	// line enables follow the stored byte one flop later
	property p_dio; bus_i.wr && bus_i.addr == dacsio_pkg::OFF_DIO |-> ##2 dio_oe_o == ~$past(bus_i.wdata, 2); endproperty
	a_dio: assert property (p_dio) else $error("line drive wrong");
endmodule
`default_nettype wire

// [tb/tb_top.sv]
// Purpose: self-checking bench for the card register block
// Assumes: timer ticks shortened to 4 and 8 clocks
// Notes: inputs change on the falling edge
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int FAST = 4;
	localparam int SLOW = 8;
	localparam int DIV = 3;
	logic clk_i = 0, reset_i = 1, load_ext_i = 0, run = 0, fast = 0, ev_clr = 0, ld_en = 0, tm_en = 0;
	dacsio_pkg::dacsio_bus_t bus_i = '0;
	logic [7:0] rdata_o, dio_in_i, dio_out_o, dio_oe_o, ext_low = 8'h00;
	logic rvalid_o, load_irq_o, timer_event_o, timer_irq_o, timer_pin_o;
	logic [3:0] pair_hold_o, pair_release_o;
	int fail_count = 0, n_checks = 0, cyc = 0;
	// ==========
	// design and connector
	dacsio_regs #(.FAST_CYCLES(FAST), .SLOW_CYCLES(SLOW)) dut_u (.clk_i, .reset_i, .bus_i, .rdata_o, .rvalid_o,
		.load_ext_i, .timer_run_i(run), .timer_fast_i(fast), .timer_event_clr_i(ev_clr), .load_irq_en_i(ld_en),
		.timer_irq_en_i(tm_en), .load_irq_o, .timer_event_o, .timer_irq_o, .timer_pin_o, .pair_hold_o,
		.pair_release_o, .dio_in_i, .dio_out_o, .dio_oe_o);
	dacsio_far_end far_u (.dio_oe_i(dio_oe_o), .dio_drv_i(dio_out_o), .ext_low_i(ext_low), .dio_pin_o(dio_in_i));
	initial forever #10 clk_i = ~clk_i;
	// hang guard, far above the expected run
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fail_count++;
			final_report();
		end
	end
	// ==========
	// shared tasks
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		bus_i <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
		@(negedge clk_i);
		bus_i <= '0;
		@(negedge clk_i);
	endtask
	// answer stands only in the cycle after the strobe edge
	task automatic rd(input logic [2:0] a, input logic [7:0] exp);
		bus_i <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
		@(negedge clk_i);
		bus_i <= '0;
		chk({7'h0, rvalid_o}, 8'h01);
		chk(rdata_o, exp);
	endtask
	// wide pulse so the synchroniser sees it
	task automatic pulse_load;
		load_ext_i <= 1;
		repeat (3) @(negedge clk_i);
		load_ext_i <= 0;
		repeat (4) @(negedge clk_i);
	endtask
	// cycles between two pin toggles; first interval skipped
	task automatic span(input logic [7:0] exp);
		logic [7:0] n;
		logic p;
		n = 8'h00;
		repeat (2) begin
			p = timer_pin_o;
			n = 8'h00;
			while (timer_pin_o === p && n < 8'hff) begin
				@(negedge clk_i);
				n++;
			end
		end
		chk(n, exp);
	endtask
	// ==========
	// scenarios
	task automatic t_simul;
		rd(3'h3, 8'h00);
		wr(3'h3, 8'h0f);
		rd(3'h3, 8'h0f);
		chk({4'h0, pair_hold_o}, 8'h0f);
		bus_i <= '{rd: 1'b0, wr: 1'b1, addr: 3'h3, wdata: 8'h05};
		@(negedge clk_i);
		bus_i <= '0;
		chk({4'h0, pair_release_o}, 8'h0a);
		@(negedge clk_i);
		chk({4'h0, pair_release_o}, 8'h00);
		chk({4'h0, pair_hold_o}, 8'h05);
		pulse_load();
		chk({4'h0, pair_hold_o}, 8'h00);
		chk({7'h0, load_irq_o}, 8'h00);
		ld_en <= 1;
		repeat (2) @(negedge clk_i);
		chk({7'h0, load_irq_o}, 8'h01);
		wr(3'h3, 8'h00);
		rd(3'h3, 8'h10);
		wr(3'h3, 8'h10);
		rd(3'h3, 8'h00);
		chk({7'h0, load_irq_o}, 8'h00);
		pulse_load();
		chk({7'h0, load_irq_o}, 8'h01);
		wr(3'h3, 8'h10);
		ld_en <= 0;
	endtask
	task automatic t_timer;
		rd(3'h4, 8'h00);
		wr(3'h4, 8'(DIV));
		rd(3'h4, 8'(DIV));
		tm_en <= 1;
		fast <= 1;
		run <= 1;
		span(8'((DIV + 1) * FAST));
		chk({6'h0, timer_event_o, timer_irq_o}, 8'h03);
		ev_clr <= 1;
		@(negedge clk_i);
		ev_clr <= 0;
		tm_en <= 0;
		chk({6'h0, timer_event_o, timer_irq_o}, 8'h00);
		fast <= 0;
		span(8'((DIV + 1) * SLOW));
		chk({6'h0, timer_event_o, timer_irq_o}, 8'h02);
		rd(3'h4, 8'(DIV));
		run <= 0;
		repeat (2) @(negedge clk_i);
		chk({6'h0, timer_event_o, timer_pin_o}, 8'h00);
	endtask
	task automatic t_dio;
		rd(3'h5, 8'hff);
		ext_low <= 8'hf0;
		wr(3'h5, 8'h5a);
		chk(dio_oe_o, 8'ha5);
		chk(dio_out_o, 8'h00);
		repeat (2) @(negedge clk_i);
		rd(3'h5, 8'h0a);
		wr(3'h5, 8'hff);
		repeat (2) @(negedge clk_i);
		rd(3'h5, 8'h0f);
		rd(3'h7, 8'h00);
	endtask
	initial begin
		repeat (12) @(negedge clk_i);
		reset_i <= 0;
		@(negedge clk_i);
		t_simul();
		t_timer();
		t_dio();
		final_report();
	end
	task automatic final_report;
		if (fail_count == 0 && n_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
endmodule
bind dacsio_regs dacsio_regs_sva sva_u (.clk_i, .reset_i, .bus_i, .rdata_o, .rvalid_o, .load_irq_en_i,
	.load_irq_o, .timer_run_i, .timer_event_o, .timer_irq_o, .timer_pin_o, .pair_hold_o, .pair_release_o,
	.dio_oe_o);
`default_nettype wire
